// *** tcu_pkg.sv ***
/*
 * tcu_pkg: register map, field positions, reset values and mode codes
 * for the eight-bit timer/counter with two compare channels.
 * Assumes a 32-bit classic Wishbone slave with word-aligned registers.
 */
package tcu_pkg;
    // register byte offsets
    localparam logic [4:0] ADDR_CONTROL_A = 5'h00;
    localparam logic [4:0] ADDR_CONTROL_B = 5'h04;
    localparam logic [4:0] ADDR_COUNTER = 5'h08;
    localparam logic [4:0] ADDR_COMPARE_A = 5'h0C;
    localparam logic [4:0] ADDR_COMPARE_B = 5'h10;
    localparam logic [4:0] ADDR_IRQ_FLAG = 5'h14;
    localparam logic [4:0] ADDR_IRQ_MASK = 5'h18;
    localparam logic [4:0] ADDR_ASYNC_STATE = 5'h1C;
    localparam int ADDR_W = 5;
    // control_register_a fields
    localparam int CRA_WGM0 = 0;
    localparam int CRA_WGM1 = 1;
    localparam int CRA_COMB_LO = 4;
    localparam int CRA_COMA_LO = 6;
    // control_register_b fields
    localparam int CRB_CS_LO = 0;
    localparam int CRB_WGM2 = 3;
    localparam int CRB_PRR = 7;
    // flag / mask and async state bit positions
    localparam int FLG_OVF = 0;
    localparam int FLG_MA = 1;
    localparam int FLG_MB = 2;
    localparam int ASR_AS = 3;
    // constants
    localparam logic [7:0] CNT_BOTTOM = 8'h00;
    localparam logic [7:0] CNT_MAX = 8'hFF;
    localparam logic [7:0] BYTE_ZERO = 8'h00;
    localparam logic [2:0] CS_STOP = 3'h0;
    localparam logic [2:0] CS_CORE = 3'h1;
    localparam logic [2:0] WGM_NORMAL = 3'h0;
    localparam logic [2:0] WGM_CTC = 3'h2;
    localparam logic [2:0] WGM_FAST_MAX = 3'h3;
    localparam logic [2:0] WGM_FAST_OCRA = 3'h7;
    localparam logic [1:0] COM_OFF = 2'h0;
    localparam logic [1:0] COM_TOGGLE = 2'h1;
    localparam logic [1:0] COM_CLEAR = 2'h2;
    localparam logic [1:0] COM_SET = 2'h3;
    localparam logic PRR_RESET = 1'b1;
endpackage

// *** tcu_compare_channel.sv ***
/*
 * tcu_compare_channel: one double-buffered compare channel with its
 * comparator, delayed match flag and waveform output.
 * Assumes tick pulses come on core_clk_i and writes are single cycle.
 */
`timescale 1ns/100ps
module tcu_compare_channel
    import tcu_pkg::*;
(
    input wire logic core_clk_i,
    input wire logic reset_i,
    input wire logic tick_i,
    input wire logic [7:0] count_i,
    input wire logic [2:0] wgm_i,
    input wire logic [1:0] com_i,
    input wire logic is_bottom_i,
    input wire logic is_top_i,
    input wire logic wr_i,
    input wire logic [7:0] wdata_i,
    input wire logic flag_clr_i,
    output logic [7:0] shadow_o,
    output logic [7:0] active_o,
    output logic match_o,
    output logic flag_o,
    output logic wave_o
);
    logic match_d;
    logic pwm_mode;

    assign pwm_mode = (wgm_i == WGM_FAST_MAX) || (wgm_i == WGM_FAST_OCRA);

    // buffered compare copy
    // pwm modes load at top so a period is never cut short
    always_ff @(posedge core_clk_i) begin
        if (reset_i) begin
            shadow_o <= BYTE_ZERO;
            active_o <= BYTE_ZERO;
        end else begin
            if (wr_i) begin
                shadow_o <= wdata_i;
            end
            if (!pwm_mode) begin
                active_o <= wr_i ? wdata_i : shadow_o;
            end else if (tick_i && is_top_i) begin
                active_o <= shadow_o;
            end
        end
    end

    assign match_o = (count_i == active_o);

    // flag one tick later; set wins over clear
    always_ff @(posedge core_clk_i) begin
        if (reset_i) begin
            match_d <= 1'b0;
            flag_o <= 1'b0;
        end else begin
            if (tick_i) begin
                match_d <= match_o;
            end
            if (tick_i && match_d) begin
                flag_o <= 1'b1;
            end else if (flag_clr_i) begin
                flag_o <= 1'b0;
            end
        end
    end

    // waveform from match, mode and output mode
    // com_i is used live, never buffered
    always_ff @(posedge core_clk_i) begin
        if (reset_i) begin
            wave_o <= 1'b0;
        end else if (tick_i && com_i != COM_OFF) begin
            if (pwm_mode) begin
                if (match_o && !is_top_i) begin
                    wave_o <= (com_i == COM_SET);
                end else if (is_bottom_i) begin
                    wave_o <= (com_i != COM_SET);
                end
            end else if (match_o) begin
                case (com_i)
                    COM_TOGGLE: wave_o <= ~wave_o;
                    COM_CLEAR: wave_o <= 1'b0;
                    COM_SET: wave_o <= 1'b1;
                    default: wave_o <= wave_o;
                endcase
            end
        end
    end

    // checker helper: did the previous tick see a match
    // kept apart from match_d so the check does not lean on it
    logic chk_match_tick;
    always_ff @(posedge core_clk_i) begin
        if (reset_i) begin
            chk_match_tick <= 1'b0;
        end else if (tick_i) begin
            chk_match_tick <= (count_i == active_o);
        end
    end

    // flag follows the match by one tick
    a_flag_delay: assert property (@(posedge core_clk_i) disable iff (reset_i)
        (tick_i && chk_match_tick) |=> flag_o)
        else $error("match flag not set one tick after match");
    // clear without set drops the flag
    a_flag_clear: assert property (@(posedge core_clk_i) disable iff (reset_i)
        (flag_clr_i && !(tick_i && match_d)) |=> !flag_o)
        else $error("flag not cleared by write one");
endmodule

// *** tcu_timer.sv ***
/*
 * tcu_timer: eight-bit timer/counter top with classic Wishbone slave,
 * counter unit, mode decode, crystal clock choice and two compare
 * channels. Assumes the crystal and prescaler pulses arrive
 * asynchronously and are synchronised here.
 */
`timescale 1ns/100ps
module tcu_timer
    import tcu_pkg::*;
(
    input wire logic core_clk_i,
    input wire logic reset_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [31:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic prescale_tick_i,
    input wire logic crystal_pin_in_i,
    input wire logic irq_ovf_serviced_i,
    input wire logic irq_ma_serviced_i,
    input wire logic irq_mb_serviced_i,
    output logic irq_ovf_o,
    output logic irq_ma_o,
    output logic irq_mb_o,
    output logic compare_output_pin_a_o,
    output logic compare_output_pin_b_o
);
    logic [7:0] control_register_a;
    logic [7:0] control_register_b;
    logic [7:0] counter_value;
    logic [2:0] irq_mask_register;
    logic async_clock_select;
    logic overflow_flag;
    logic [2:0] xtal_sync;
    logic [1:0] pre_sync;
    logic [2:0] waveform_mode_field;
    logic [2:0] clock_select_field;
    logic power_reduction_timer_bit;
    logic timer_clock;
    logic direction_up;
    logic is_bottom;
    logic is_max;
    logic is_top;
    logic [7:0] top_value;
    logic do_clear;
    logic [7:0] next_counter;
    logic wb_hit;
    logic wr_en;
    logic rd_valid;
    logic [31:0] next_rdata;
    logic [7:0] shadow_a;
    logic [7:0] shadow_b;
    logic [7:0] active_a;
    logic [7:0] active_b;
    logic match_a;
    logic match_b;
    logic match_flag_a;
    logic match_flag_b;
    logic clr_ma;
    logic clr_mb;

    // byte-lane aware write of the low lane
    function automatic logic [7:0] lane0(input logic [7:0] old_v,
                                         input logic [3:0] sel,
                                         input logic [31:0] d);
        lane0 = sel[0] ? d[7:0] : old_v;
    endfunction

    function automatic logic wr_to(input logic [4:0] a);
        wr_to = wr_en && (wb_adr_i[ADDR_W-1:0] == a) && wb_sel_i[0];
    endfunction

    // mode field split across the two control registers
    assign waveform_mode_field = {control_register_b[CRB_WGM2],
                                  control_register_a[CRA_WGM1],
                                  control_register_a[CRA_WGM0]};
    assign clock_select_field = control_register_b[CRB_CS_LO +: 3];
    assign power_reduction_timer_bit = control_register_b[CRB_PRR];

    // wishbone: one-cycle ack, dropped the cycle after
    assign wb_hit = wb_cyc_i && wb_stb_i && !wb_ack_o;
    // writes land on the ack edge, while the master still holds the request
    assign wr_en = wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o;
    assign rd_valid = (wb_adr_i[31:ADDR_W] == '0) && (wb_adr_i[1:0] == 2'h0);

    always_ff @(posedge core_clk_i) begin
        if (reset_i) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= '0;
        end else begin
            wb_ack_o <= wb_hit;
            wb_dat_o <= next_rdata;
        end
    end

    // read mux; unmapped reads return zero and still ack
    always_comb begin
        next_rdata = '0;
        if (rd_valid) begin
            case (wb_adr_i[ADDR_W-1:0])
                ADDR_CONTROL_A: next_rdata[7:0] = control_register_a;
                ADDR_CONTROL_B: next_rdata[7:0] = control_register_b;
                ADDR_COUNTER: next_rdata[7:0] = counter_value;
                ADDR_COMPARE_A: next_rdata[7:0] = shadow_a;
                ADDR_COMPARE_B: next_rdata[7:0] = shadow_b;
                ADDR_IRQ_FLAG: next_rdata[2:0] =
                    {match_flag_b, match_flag_a, overflow_flag};
                ADDR_IRQ_MASK: next_rdata[2:0] = irq_mask_register;
                ADDR_ASYNC_STATE: next_rdata[ASR_AS] = async_clock_select;
                default: next_rdata = '0;
            endcase
        end
    end

    // control registers reset to zero: timer stopped
    always_ff @(posedge core_clk_i) begin
        if (reset_i) begin
            control_register_a <= BYTE_ZERO;
            control_register_b <= BYTE_ZERO;
            irq_mask_register <= 3'h0;
            async_clock_select <= 1'b0;
        end else if (rd_valid) begin
            if (wr_to(ADDR_CONTROL_A)) begin
                control_register_a <= lane0(control_register_a, wb_sel_i,
                                            wb_dat_i);
            end
            if (wr_to(ADDR_CONTROL_B)) begin
                control_register_b <= lane0(control_register_b, wb_sel_i,
                                            wb_dat_i);
            end
            if (wr_to(ADDR_IRQ_MASK)) begin
                irq_mask_register <= wb_dat_i[2:0];
            end
            if (wr_to(ADDR_ASYNC_STATE)) begin
                async_clock_select <= wb_dat_i[ASR_AS];
            end
        end
    end

    // two-flop synchronisers, then edge detect on the crystal only
    always_ff @(posedge core_clk_i) begin
        if (reset_i) begin
            xtal_sync <= 3'h0;
            pre_sync <= 2'h0;
        end else begin
            xtal_sync <= {xtal_sync[1:0], crystal_pin_in_i};
            pre_sync <= {pre_sync[0], prescale_tick_i};
        end
    end

    // I/O clock by default, crystal rising edge when async set
    // select zero stops; power-reduction holds module off
    // prescale taps are external; with async clear, any nonzero select other than 1 uses them
    always_comb begin
        if (power_reduction_timer_bit == PRR_RESET ||
            clock_select_field == CS_STOP) begin
            timer_clock = 1'b0;
        end else if (async_clock_select) begin
            timer_clock = xtal_sync[1] && !xtal_sync[2];
        end else if (clock_select_field == CS_CORE) begin
            timer_clock = 1'b1;
        end else begin
            timer_clock = pre_sync[1];
        end
    end

    assign is_bottom = (counter_value == CNT_BOTTOM);
    assign is_max = (counter_value == CNT_MAX);
    // top is max or compare A by mode
    assign top_value = (waveform_mode_field == WGM_CTC ||
                        waveform_mode_field == WGM_FAST_OCRA) ?
                       active_a : CNT_MAX;
    assign is_top = (counter_value == top_value);
    // supported modes are single slope, so direction stays up
    assign direction_up = 1'b1;

    // clear on A match; fast pwm restarts after top
    always_comb begin
        do_clear = 1'b0;
        case (waveform_mode_field)
            WGM_CTC: do_clear = match_a;
            WGM_FAST_MAX, WGM_FAST_OCRA: do_clear = is_top;
            default: do_clear = 1'b0;
        endcase
    end

    // clear, up or down per tick
    // normal mode wraps naturally from max to bottom
    always_comb begin
        if (do_clear) begin
            next_counter = CNT_BOTTOM;
        end else if (direction_up) begin
            next_counter = counter_value + 8'h01;
        end else begin
            next_counter = counter_value - 8'h01;
        end
    end

    // cpu write beats count and clear
    always_ff @(posedge core_clk_i) begin
        if (reset_i) begin
            counter_value <= BYTE_ZERO;
        end else if (rd_valid && wr_to(ADDR_COUNTER)) begin
            counter_value <= wb_dat_i[7:0];
        end else if (timer_clock) begin
            counter_value <= next_counter;
        end
    end

    // overflow: wrap to zero, or reaching top in fast pwm
    // service clears; write one clears; set wins
    always_ff @(posedge core_clk_i) begin
        if (reset_i) begin
            overflow_flag <= 1'b0;
        end else if (timer_clock &&
                     ((waveform_mode_field == WGM_FAST_MAX ||
                       waveform_mode_field == WGM_FAST_OCRA) ? is_top :
                      is_max)) begin
            overflow_flag <= 1'b1;
        end else if (irq_ovf_serviced_i ||
                     (rd_valid && wr_to(ADDR_IRQ_FLAG) &&
                      wb_dat_i[FLG_OVF])) begin
            overflow_flag <= 1'b0;
        end
    end

    // flag clear by service or written one
    assign clr_ma = irq_ma_serviced_i ||
                    (rd_valid && wr_to(ADDR_IRQ_FLAG) && wb_dat_i[FLG_MA]);
    assign clr_mb = irq_mb_serviced_i ||
                    (rd_valid && wr_to(ADDR_IRQ_FLAG) && wb_dat_i[FLG_MB]);

    tcu_compare_channel u_chan_a (
        .core_clk_i(core_clk_i),
        .reset_i(reset_i),
        .tick_i(timer_clock),
        .count_i(counter_value),
        .wgm_i(waveform_mode_field),
        .com_i(control_register_a[CRA_COMA_LO +: 2]),
        .is_bottom_i(is_bottom),
        .is_top_i(is_top),
        .wr_i(rd_valid && wr_to(ADDR_COMPARE_A)),
        .wdata_i(wb_dat_i[7:0]),
        .flag_clr_i(clr_ma),
        .shadow_o(shadow_a),
        .active_o(active_a),
        .match_o(match_a),
        .flag_o(match_flag_a),
        .wave_o(compare_output_pin_a_o)
    );

    tcu_compare_channel u_chan_b (
        .core_clk_i(core_clk_i),
        .reset_i(reset_i),
        .tick_i(timer_clock),
        .count_i(counter_value),
        .wgm_i(waveform_mode_field),
        .com_i(control_register_a[CRA_COMB_LO +: 2]),
        .is_bottom_i(is_bottom),
        .is_top_i(is_top),
        .wr_i(rd_valid && wr_to(ADDR_COMPARE_B)),
        .wdata_i(wb_dat_i[7:0]),
        .flag_clr_i(clr_mb),
        .shadow_o(shadow_b),
        .active_o(active_b),
        .match_o(match_b),
        .flag_o(match_flag_b),
        .wave_o(compare_output_pin_b_o)
    );

    // each request gated by its mask bit
    assign irq_ovf_o = overflow_flag && irq_mask_register[FLG_OVF];
    assign irq_ma_o = match_flag_a && irq_mask_register[FLG_MA];
    assign irq_mb_o = match_flag_b && irq_mask_register[FLG_MB];

    sequence s_stopped;
        (clock_select_field == CS_STOP) && !wr_to(ADDR_COUNTER);
    endsequence

    a_stop_holds: assert property (@(posedge core_clk_i) disable iff (reset_i)
        s_stopped |=> counter_value == $past(counter_value))
        else $error("counter moved while stopped");
    a_prr_holds: assert property (@(posedge core_clk_i) disable iff (reset_i)
        power_reduction_timer_bit |-> !timer_clock)
        else $error("timer clocked while power reduced");
    a_write_wins: assert property (@(posedge core_clk_i) disable iff (reset_i)
        (rd_valid && wr_to(ADDR_COUNTER)) |=>
        counter_value == $past(wb_dat_i[7:0]))
        else $error("cpu counter write lost");
    a_ovf_normal: assert property (@(posedge core_clk_i) disable iff (reset_i)
        (timer_clock && waveform_mode_field == WGM_NORMAL && is_max &&
         !wr_to(ADDR_COUNTER))
        |=> overflow_flag && counter_value == CNT_BOTTOM)
        else $error("normal wrap without overflow");
    a_ctc_clear: assert property (@(posedge core_clk_i) disable iff (reset_i)
        (timer_clock && waveform_mode_field == WGM_CTC && match_a &&
         !wr_to(ADDR_COUNTER)) |=> counter_value == CNT_BOTTOM)
        else $error("ctc did not clear on match");
    a_fast_top: assert property (@(posedge core_clk_i) disable iff (reset_i)
        (timer_clock && waveform_mode_field == WGM_FAST_MAX && is_max &&
         !wr_to(ADDR_COUNTER)) |=> counter_value == CNT_BOTTOM)
        else $error("fast pwm mode 3 did not restart after max");
    a_count_up: assert property (@(posedge core_clk_i) disable iff (reset_i)
        (timer_clock && !do_clear && !wr_to(ADDR_COUNTER)) |=>
        counter_value == $past(counter_value) + 8'h01)
        else $error("counter did not increment");
    a_irq_gate: assert property (@(posedge core_clk_i) disable iff (reset_i)
        irq_ma_o == (match_flag_a && irq_mask_register[FLG_MA]))
        else $error("compare A irq not gated by mask");
    a_ack_pulse: assert property (@(posedge core_clk_i) disable iff (reset_i)
        wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
endmodule

// *** testbench.sv ***
/*
 * testbench: self-checking bench for the eight-bit timer/counter top.
 * Assumes tcu_pkg is compiled first; registers are reached through
 * classic Wishbone single cycles; one 40 MHz core clock.
 */
`timescale 1ns/100ps
module testbench
    import tcu_pkg::*;
;
    logic core_clk_i = 1'b0;
    logic reset_i = 1'b1;
    logic cyc = 1'b0, stb = 1'b0, we = 1'b0;
    logic [31:0] adr = 32'h0, wdat = 32'h0, rdat;
    logic [3:0] sel = 4'h0;
    logic ack, tick = 1'b0, xtal = 1'b0;
    logic sv_ovf = 1'b0, sv_ma = 1'b0, sv_mb = 1'b0;
    logic irq_ovf, irq_ma, irq_mb, pin_a, pin_b;
    int n_errors = 0;
    int comparisons = 0;
    logic [7:0] q, q2;
    logic s0, s1;

    // 40 MHz core clock
    always #12.5 core_clk_i = ~core_clk_i;

    tcu_timer DUT (.core_clk_i(core_clk_i), .reset_i(reset_i),
        .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
        .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
        .prescale_tick_i(tick), .crystal_pin_in_i(xtal),
        .irq_ovf_serviced_i(sv_ovf), .irq_ma_serviced_i(sv_ma),
        .irq_mb_serviced_i(sv_mb), .irq_ovf_o(irq_ovf), .irq_ma_o(irq_ma),
        .irq_mb_o(irq_mb), .compare_output_pin_a_o(pin_a),
        .compare_output_pin_b_o(pin_b));

    // verdict and end of run, shared with the watchdog
    task automatic results;
        if (n_errors == 0 && comparisons > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        comparisons++;
        if (got !== exp) begin
            n_errors++;
            $display("mismatch at %0t: saw %h expected %h", $time, got, exp);
        end
    endtask

    task automatic idle(input int n);
        repeat (n) @(posedge core_clk_i);
    endtask

    // one classic cycle; request held until ack is sampled high
    task automatic wb(input logic w, input logic [7:0] a,
                      input logic [7:0] d, output logic [7:0] r);
        int n;
        n = 0;
        @(posedge core_clk_i);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        sel <= 4'h1;
        adr <= {24'h0, a};
        wdat <= {24'h0, d};
        do begin
            @(posedge core_clk_i);
            n++;
        end while (ack !== 1'b1 && n < 50);
        r = rdat[7:0];
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
        if (n >= 50) begin
            n_errors++;
            $display("mismatch at %0t: no bus answer", $time);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic [7:0] r;
        wb(1'b1, a, d, r);
    endtask

    task automatic rd(input logic [7:0] a, output logic [7:0] r);
        wb(1'b0, a, 8'h00, r);
    endtask

    // watchdog sized well above the thousand or fewer cycles needed
    initial begin
        idle(30000);
        n_errors++;
        results();
    end

    initial begin
        idle(2);
        reset_i <= 1'b0;
        // all registers zero after reset; 0x20 is unmapped
        for (int i = 0; i <= 8; i++) begin
            rd(8'(i * 4), q);
            chk(q, 8'h00);
        end
        wr(8'(ADDR_COMPARE_A), 8'hA5);
        wr(8'(ADDR_COMPARE_B), 8'h5A);
        wr(8'(ADDR_COUNTER), 8'hC3);
        wr(8'h20, 8'h3C);
        rd(8'(ADDR_COMPARE_A), q);
        chk(q, 8'hA5);
        rd(8'(ADDR_COMPARE_B), q);
        chk(q, 8'h5A);
        rd(8'h20, q);
        chk(q, 8'h00);
        idle(10);
        rd(8'(ADDR_COUNTER), q);
        chk(q, 8'hC3);
        // normal mode run across the wrap, passing both match values
        wr(8'(ADDR_COMPARE_A), 8'h05);
        wr(8'(ADDR_COMPARE_B), 8'h0A);
        wr(8'(ADDR_COUNTER), 8'hF0);
        wr(8'(ADDR_CONTROL_B), 8'h01);
        idle(40);
        wr(8'(ADDR_CONTROL_B), 8'h00);
        rd(8'(ADDR_IRQ_FLAG), q);
        chk(q, 8'h07);
        chk({5'h0, irq_mb, irq_ma, irq_ovf}, 8'h00);
        rd(8'(ADDR_COUNTER), q);
        idle(10);
        rd(8'(ADDR_COUNTER), q2);
        chk(q2, q);
        wr(8'(ADDR_IRQ_MASK), 8'h07);
        idle(1);
        chk({5'h0, irq_mb, irq_ma, irq_ovf}, 8'h07);
        wr(8'(ADDR_IRQ_FLAG), 8'h00);
        rd(8'(ADDR_IRQ_FLAG), q);
        chk(q, 8'h07);
        wr(8'(ADDR_IRQ_FLAG), 8'h01);
        rd(8'(ADDR_IRQ_FLAG), q);
        chk(q, 8'h06);
        // serviced pulses clear their own flag only
        @(posedge core_clk_i) sv_ma <= 1'b1;
        @(posedge core_clk_i) sv_ma <= 1'b0;
        rd(8'(ADDR_IRQ_FLAG), q);
        chk(q, 8'h04);
        @(posedge core_clk_i) sv_mb <= 1'b1;
        @(posedge core_clk_i) sv_mb <= 1'b0;
        idle(1);
        chk({7'h0, irq_mb}, 8'h00);
        // write while running wins over the count
        wr(8'(ADDR_CONTROL_B), 8'h01);
        wr(8'(ADDR_COUNTER), 8'h80);
        wr(8'(ADDR_CONTROL_B), 8'h00);
        rd(8'(ADDR_COUNTER), q);
        chk({7'h0, q >= 8'h80 && q <= 8'h88}, 8'h01);
        // clear-on-match with compare A toggling pin A
        wr(8'(ADDR_COUNTER), 8'h00);
        wr(8'(ADDR_IRQ_FLAG), 8'h07);
        wr(8'(ADDR_CONTROL_A), 8'h42);
        wr(8'(ADDR_CONTROL_B), 8'h01);
        s0 = 1'b0;
        s1 = 1'b0;
        for (int i = 0; i < 8; i++) begin
            rd(8'(ADDR_COUNTER), q);
            chk({7'h0, q <= 8'h05}, 8'h01);
            if (pin_a === 1'b0) s0 = 1'b1;
            if (pin_a === 1'b1) s1 = 1'b1;
        end
        chk({6'h0, s1, s0}, 8'h03);
        wr(8'(ADDR_CONTROL_B), 8'h00);
        rd(8'(ADDR_IRQ_FLAG), q);
        chk(q & 8'h03, 8'h02);
        // fast PWM, top from compare A, pin B non-inverted
        wr(8'(ADDR_COMPARE_A), 8'h20);
        wr(8'(ADDR_COMPARE_B), 8'h10);
        wr(8'(ADDR_IRQ_FLAG), 8'h07);
        wr(8'(ADDR_CONTROL_A), 8'h23);
        wr(8'(ADDR_CONTROL_B), 8'h09);
        s0 = 1'b0;
        s1 = 1'b0;
        for (int i = 0; i < 200; i++) begin
            @(posedge core_clk_i);
            if (pin_b === 1'b0) s0 = 1'b1;
            if (pin_b === 1'b1) s1 = 1'b1;
        end
        chk({6'h0, s1, s0}, 8'h03);
        for (int i = 0; i < 8; i++) begin
            rd(8'(ADDR_COUNTER), q);
            chk({7'h0, q <= 8'h20}, 8'h01);
        end
        rd(8'(ADDR_IRQ_FLAG), q);
        chk(q & 8'h01, 8'h01);
        // mode 3: top is the fixed maximum, so values above A appear
        wr(8'(ADDR_CONTROL_B), 8'h01);
        s1 = 1'b0;
        for (int i = 0; i < 40; i++) begin
            rd(8'(ADDR_COUNTER), q);
            if (q > 8'h20) s1 = 1'b1;
        end
        chk({7'h0, s1}, 8'h01);
        // power reduction holds the counter even with a clock chosen
        wr(8'(ADDR_CONTROL_B), 8'h00);
        wr(8'(ADDR_CONTROL_A), 8'h00);
        wr(8'(ADDR_COUNTER), 8'h10);
        wr(8'(ADDR_CONTROL_B), 8'h81);
        idle(30);
        rd(8'(ADDR_COUNTER), q);
        chk(q, 8'h10);
        // prescaler tap: no tick, no count; ten ticks, about ten counts
        wr(8'(ADDR_CONTROL_B), 8'h00);
        wr(8'(ADDR_COUNTER), 8'h00);
        wr(8'(ADDR_CONTROL_B), 8'h02);
        idle(20);
        rd(8'(ADDR_COUNTER), q);
        chk(q, 8'h00);
        @(posedge core_clk_i) tick <= 1'b1;
        idle(10);
        tick <= 1'b0;
        idle(6);
        wr(8'(ADDR_CONTROL_B), 8'h00);
        rd(8'(ADDR_COUNTER), q);
        chk({7'h0, q >= 8'h08 && q <= 8'h0C}, 8'h01);
        // crystal: four rising edges give four counts
        wr(8'(ADDR_COUNTER), 8'h00);
        wr(8'(ADDR_ASYNC_STATE), 8'h08);
        wr(8'(ADDR_CONTROL_B), 8'h01);
        for (int i = 0; i < 4; i++) begin
            idle(6);
            xtal <= 1'b1;
            idle(6);
            xtal <= 1'b0;
        end
        idle(10);
        wr(8'(ADDR_CONTROL_B), 8'h00);
        rd(8'(ADDR_COUNTER), q);
        chk(q, 8'h04);
        results();
    end
endmodule
